// >>> rtl/motion_event_interrupts.sv
// Interrupt flags, routing, polarity and register file of the motion sensor
// Overview of operation
// - Two separate push-pull interrupt outputs, always actively driven.
// - Pins idle low after reset; invert bit in format register flips both.
// - A source affects pins only while its enable bit is set.
// - Pin select bit routes each enabled source to pin a or pin b.
// - All detectors run together; sources on one pin share it.
// - Flags latch; data flags clear on sample reads once condition ends.
// - Reading the cause register clears the non-data flags.
// - New-sample flag set on each new sample, cleared by a sample read when none remains.
// - Single tap: above tap threshold for less than maximum duration.
// - Double tap: second tap starts after latency, within the window.
// - Activity: any enabled axis above motion threshold.
// - Stillness: all enabled axes below threshold longer than still time.
// - Free fall: all axes below fall threshold longer than fall time.
// - Free fall always uses all axes, dc compare, timer up to 1.28 s.
// - Watermark set at configured level, cleared when reads drop count below.
// - Overrun set on overwritten data, cleared when buffer contents read.
`timescale 1ns/1ps
`default_nettype none
module motion_event_interrupts #(
    parameter int TICK_CYCLES = motion_irq_pkg::TICK_CYCLES
) (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    input  wire logic [5:0]                  reg_addr_in,
    input  wire logic [7:0]                  reg_wdata_in,
    output logic [7:0]                       reg_rdata_out,
    input  wire logic                        sample_valid_in,
    input  wire motion_irq_pkg::sample_s     sample_in,
    input  wire motion_irq_pkg::buf_status_s buf_status_in,
    output logic                             irq_pin_a_out,
    output logic                             irq_pin_b_out
);
    import motion_irq_pkg::*;

    logic [NUM_RW-1:0][7:0] rw_ff, nxt_rw;
    logic [7:0]   cause_ff, nxt_cause;
    logic [7:0]   rdata_ff, nxt_rdata;
    sample_s      sample_ff, nxt_sample;
    logic         new_ff;
    logic         pin_a_ff, nxt_pin_a;
    logic         pin_b_ff, nxt_pin_b;
    logic [7:0]   set_vec, clr_vec;
    logic [7:0]   enable, pin_sel;
    logic         invert;
    logic         src_rd, data_rd;
    logic         below_level;
    detect_cfg_s  cfg;
    event_s       events;
    logic [2:0]   byte_idx;

    assign enable  = rw_ff[IDX_ENABLE];
    assign pin_sel = rw_ff[IDX_PIN_SEL];
    assign invert  = rw_ff[IDX_FORMAT][FMT_INVERT_BIT];
    assign src_rd  = reg_rd_in && reg_addr_in == ADDR_IRQ_CAUSE;
    assign data_rd = reg_rd_in && reg_addr_in >= ADDR_SAMPLE_FIRST && reg_addr_in <= ADDR_SAMPLE_LAST;
    assign below_level = buf_status_in.count < {1'b0, buf_status_in.level};
    assign byte_idx = 3'(reg_addr_in - ADDR_SAMPLE_FIRST);

    assign cfg.tap_thr    = rw_ff[IDX_TAP_THR];
    assign cfg.tap_dur    = rw_ff[IDX_TAP_DUR];
    assign cfg.tap_lat    = rw_ff[IDX_TAP_LAT];
    assign cfg.tap_win    = rw_ff[IDX_TAP_WIN];
    assign cfg.act_thr    = rw_ff[IDX_ACT_THR];
    assign cfg.still_thr  = rw_ff[IDX_STILL_THR];
    assign cfg.still_time = rw_ff[IDX_STILL_TIM];
    assign cfg.axis_ctl   = rw_ff[IDX_AXIS_CTL];
    assign cfg.fall_thr   = rw_ff[IDX_FALL_THR];
    assign cfg.fall_time  = rw_ff[IDX_FALL_TIM];

    // All detectors evaluate concurrently on the held sample
    motion_detect #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_detect (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .sample_new_in (new_ff),
        .sample_in     (sample_ff),
        .cfg_in        (cfg),
        .events_out    (events)
    );

    // Writable registers
    for (genvar i = 0; i < NUM_RW; i++) begin : g_rw
        always_comb begin
            nxt_rw[i] = rw_ff[i];
            if (reg_wr_in && reg_addr_in == RW_ADDR[i]) begin
                nxt_rw[i] = reg_wdata_in;
            end
        end
    end

    // Sample holding
    always_comb begin
        nxt_sample = sample_ff;
        if (sample_valid_in) begin
            nxt_sample = sample_in;
        end
    end

    // Latched cause flags: set wins over clear
    always_comb begin
        set_vec = 8'h00;
        clr_vec = 8'h00;
        set_vec[BIT_NEW_SAMPLE] = sample_valid_in;
        set_vec[BIT_SINGLE_TAP] = events.single_tap;
        set_vec[BIT_DOUBLE_TAP] = events.double_tap;
        set_vec[BIT_ACTIVITY]   = events.activity;
        set_vec[BIT_STILLNESS]  = events.stillness;
        set_vec[BIT_FREE_FALL]  = events.free_fall;
        set_vec[BIT_WATERMARK]  = buf_status_in.count == {1'b0, buf_status_in.level};
        set_vec[BIT_OVERRUN]    = buf_status_in.overwrite;
        clr_vec[BIT_NEW_SAMPLE] = data_rd && buf_status_in.count == 6'h00;
        clr_vec[BIT_WATERMARK]  = data_rd && below_level;
        clr_vec[BIT_OVERRUN]    = data_rd;
        clr_vec[BIT_SINGLE_TAP] = src_rd;
        clr_vec[BIT_DOUBLE_TAP] = src_rd;
        clr_vec[BIT_ACTIVITY]   = src_rd;
        clr_vec[BIT_STILLNESS]  = src_rd;
        clr_vec[BIT_FREE_FALL]  = src_rd;
        nxt_cause = set_vec | (cause_ff & ~clr_vec);
    end

    // Pin combining and polarity
    always_comb begin
        nxt_pin_a = (|(cause_ff & enable & ~pin_sel)) ^ invert;
        nxt_pin_b = (|(cause_ff & enable & pin_sel)) ^ invert;
    end

    // Read data, answered one cycle after the read strobe
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd_in) begin
            nxt_rdata = 8'h00;
            for (int i = 0; i < NUM_RW; i++) begin
                if (reg_addr_in == RW_ADDR[i]) begin
                    nxt_rdata = rw_ff[i];
                end
            end
            if (reg_addr_in == ADDR_IRQ_CAUSE) begin
                nxt_rdata = cause_ff;
            end
            if (data_rd) begin
                case (byte_idx)
                    3'h0: nxt_rdata = sample_ff.x[7:0];
                    3'h1: nxt_rdata = sample_ff.x[15:8];
                    3'h2: nxt_rdata = sample_ff.y[7:0];
                    3'h3: nxt_rdata = sample_ff.y[15:8];
                    3'h4: nxt_rdata = sample_ff.z[7:0];
                    3'h5: nxt_rdata = sample_ff.z[15:8];
                    default: nxt_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rw_ff     <= {NUM_RW{REG_RESET}};
            cause_ff  <= 8'h00;
            rdata_ff  <= 8'h00;
            sample_ff <= '0;
            new_ff    <= 1'b0;
            pin_a_ff  <= 1'b0;
            pin_b_ff  <= 1'b0;
        end else begin
            rw_ff     <= nxt_rw;
            cause_ff  <= nxt_cause;
            rdata_ff  <= nxt_rdata;
            sample_ff <= nxt_sample;
            new_ff    <= sample_valid_in;
            pin_a_ff  <= nxt_pin_a;
            pin_b_ff  <= nxt_pin_b;
        end
    end

    // Both pins driven from flops at all times
    assign irq_pin_a_out = pin_a_ff;
    assign irq_pin_b_out = pin_b_ff;
    assign reg_rdata_out = rdata_ff;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    chk_pin_a_routing: assert property (
        (|(cause_ff & enable & ~pin_sel)) && !invert |=> irq_pin_a_out)
        else $error("pin a not asserted for routed flag");

    chk_pin_b_routing: assert property (
        !(|(cause_ff & enable & pin_sel)) && invert |=> irq_pin_b_out)
        else $error("pin b not idle high when inverted");

    chk_idle_polarity: assert property (
        cause_ff == 8'h00 |=> (irq_pin_a_out == $past(invert)) && (irq_pin_b_out == $past(invert)))
        else $error("idle pin level does not follow polarity");

    chk_enable_gate: assert property (
        enable == 8'h00 && !invert |=> !irq_pin_a_out && !irq_pin_b_out)
        else $error("disabled sources reached a pin");

    chk_shared_pin: assert property (
        cause_ff[BIT_SINGLE_TAP] && cause_ff[BIT_FREE_FALL] && enable[BIT_SINGLE_TAP]
        && !pin_sel[BIT_SINGLE_TAP] && !invert |=> irq_pin_a_out)
        else $error("shared pin a lost a source");

    chk_flag_latched: assert property (
        cause_ff[BIT_ACTIVITY] && !src_rd |=> cause_ff[BIT_ACTIVITY])
        else $error("activity flag dropped without a cause read");

    chk_cause_read_clear: assert property (
        src_rd && !events.free_fall |=> !cause_ff[BIT_FREE_FALL] && rdata_ff == $past(cause_ff))
        else $error("cause read did not clear or return flags");

    chk_new_sample_flag: assert property (
        sample_valid_in |=> cause_ff[BIT_NEW_SAMPLE] && sample_ff == $past(sample_in))
        else $error("new sample not flagged");

    chk_new_sample_clear: assert property (
        data_rd && buf_status_in.count == 6'h00 && !sample_valid_in |=> !cause_ff[BIT_NEW_SAMPLE])
        else $error("new sample flag stuck with no data left");

    chk_watermark: assert property (
        buf_status_in.count == {1'b0, buf_status_in.level} |=> cause_ff[BIT_WATERMARK])
        else $error("watermark not flagged at level");

    chk_overrun: assert property (
        data_rd && !buf_status_in.overwrite |=> !cause_ff[BIT_OVERRUN])
        else $error("overrun flag not cleared by data read");

    chk_tap_to_pin: assert property (
        events.single_tap && enable[BIT_SINGLE_TAP] && pin_sel[BIT_SINGLE_TAP] && !invert
        ##1 !invert |=> irq_pin_b_out)
        else $error("single tap did not reach pin b within two cycles");

    cov_double_tap: cover property (events.double_tap);
    cov_free_fall: cover property (events.free_fall);
    cov_stillness: cover property (events.stillness);
    cov_pin_a_rise: cover property (!irq_pin_a_out ##1 irq_pin_a_out);

endmodule
`default_nettype wire

// >>> pkg/motion_irq_pkg.sv
// Register map, field positions, timing counts and carriers for the motion interrupt logic
package motion_irq_pkg;

    // Register offsets
    localparam logic [5:0] ADDR_TAP_THRESHOLD    = 6'h1d;
    localparam logic [5:0] ADDR_TAP_MAX_DURATION = 6'h21;
    localparam logic [5:0] ADDR_TAP_LATENCY      = 6'h22;
    localparam logic [5:0] ADDR_SECOND_TAP_WIN   = 6'h23;
    localparam logic [5:0] ADDR_MOTION_THRESHOLD = 6'h24;
    localparam logic [5:0] ADDR_STILL_THRESHOLD  = 6'h25;
    localparam logic [5:0] ADDR_STILL_TIME       = 6'h26;
    localparam logic [5:0] ADDR_MOTION_AXIS_CTL  = 6'h27;
    localparam logic [5:0] ADDR_FALL_THRESHOLD   = 6'h28;
    localparam logic [5:0] ADDR_FALL_TIME        = 6'h29;
    localparam logic [5:0] ADDR_IRQ_ENABLE_MASK  = 6'h2e;
    localparam logic [5:0] ADDR_IRQ_PIN_SELECT   = 6'h2f;
    localparam logic [5:0] ADDR_IRQ_CAUSE        = 6'h30;
    localparam logic [5:0] ADDR_OUTPUT_FORMAT    = 6'h31;
    localparam logic [5:0] ADDR_SAMPLE_FIRST     = 6'h32;
    localparam logic [5:0] ADDR_SAMPLE_LAST      = 6'h37;

    // Writable register file: index of each entry and its address
    localparam int NUM_RW = 13;
    localparam int IDX_TAP_THR   = 0;
    localparam int IDX_TAP_DUR   = 1;
    localparam int IDX_TAP_LAT   = 2;
    localparam int IDX_TAP_WIN   = 3;
    localparam int IDX_ACT_THR   = 4;
    localparam int IDX_STILL_THR = 5;
    localparam int IDX_STILL_TIM = 6;
    localparam int IDX_AXIS_CTL  = 7;
    localparam int IDX_FALL_THR  = 8;
    localparam int IDX_FALL_TIM  = 9;
    localparam int IDX_ENABLE    = 10;
    localparam int IDX_PIN_SEL   = 11;
    localparam int IDX_FORMAT    = 12;
    localparam logic [NUM_RW-1:0][5:0] RW_ADDR = {
        ADDR_OUTPUT_FORMAT, ADDR_IRQ_PIN_SELECT, ADDR_IRQ_ENABLE_MASK, ADDR_FALL_TIME,
        ADDR_FALL_THRESHOLD, ADDR_MOTION_AXIS_CTL, ADDR_STILL_TIME, ADDR_STILL_THRESHOLD,
        ADDR_MOTION_THRESHOLD, ADDR_SECOND_TAP_WIN, ADDR_TAP_LATENCY, ADDR_TAP_MAX_DURATION,
        ADDR_TAP_THRESHOLD};
    localparam logic [7:0] REG_RESET = 8'h00;

    // Source bit positions in enable, pin select and cause registers
    localparam int BIT_NEW_SAMPLE = 7;
    localparam int BIT_SINGLE_TAP = 6;
    localparam int BIT_DOUBLE_TAP = 5;
    localparam int BIT_ACTIVITY   = 4;
    localparam int BIT_STILLNESS  = 3;
    localparam int BIT_FREE_FALL  = 2;
    localparam int BIT_WATERMARK  = 1;
    localparam int BIT_OVERRUN    = 0;
    localparam int FMT_INVERT_BIT = 5;
    localparam int ACT_AXIS_LSB   = 4;
    localparam int STILL_AXIS_LSB = 0;

    // Magnitude scaling: sample LSB to threshold LSB
    localparam int THRESH_SHIFT = 4;

    // Timing: base tick and register LSB weights
    localparam int CLK_KHZ       = 25000;
    localparam int TICK_US       = 625;
    localparam int TICK_CYCLES   = (CLK_KHZ * TICK_US) / 1000;
    localparam int LATENCY_LSB_US = 1250;
    localparam int FALL_LSB_US   = 5000;
    localparam int STILL_LSB_US  = 1000000;
    localparam int LAT_TICKS     = LATENCY_LSB_US / TICK_US;
    localparam int FALL_TICKS    = FALL_LSB_US / TICK_US;
    localparam int STILL_TICKS   = STILL_LSB_US / TICK_US;
    localparam int FALL_MAX_MS   = 1280;
    localparam int STILL_MAX_S   = 255;
    localparam int TIMER_W       = $clog2(STILL_MAX_S * STILL_TICKS + 2);

    typedef enum logic [2:0] {
        TAP_IDLE   = 3'b000,
        TAP_FIRST  = 3'b001,
        TAP_HOLD   = 3'b010,
        TAP_LATENT = 3'b011,
        TAP_WINDOW = 3'b100,
        TAP_SECOND = 3'b101
    } tap_state_e;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } sample_s;

    typedef struct packed {
        logic [5:0] count;
        logic [4:0] level;
        logic       overwrite;
    } buf_status_s;

    typedef struct packed {
        logic [7:0] tap_thr;
        logic [7:0] tap_dur;
        logic [7:0] tap_lat;
        logic [7:0] tap_win;
        logic [7:0] act_thr;
        logic [7:0] still_thr;
        logic [7:0] still_time;
        logic [7:0] axis_ctl;
        logic [7:0] fall_thr;
        logic [7:0] fall_time;
    } detect_cfg_s;

    typedef struct packed {
        logic single_tap;
        logic double_tap;
        logic activity;
        logic stillness;
        logic free_fall;
    } event_s;

endpackage

// >>> rtl/motion_detect.sv
// Tap, activity, stillness and free-fall detectors on the latest sample
`timescale 1ns/1ps
`default_nettype none
module motion_detect #(
    parameter int TICK_CYCLES = motion_irq_pkg::TICK_CYCLES
) (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        sample_new_in,
    input  wire motion_irq_pkg::sample_s     sample_in,
    input  wire motion_irq_pkg::detect_cfg_s cfg_in,
    output motion_irq_pkg::event_s           events_out
);
    import motion_irq_pkg::*;

    localparam int DW = $clog2(TICK_CYCLES + 1);

    logic [DW-1:0]      div_ff, nxt_div;
    logic               tick_ff, nxt_tick;
    tap_state_e         tap_ff, nxt_tap;
    logic [9:0]         cnt_ff, nxt_cnt;
    logic [1:0][TIMER_W-1:0] tmr_ff, nxt_tmr;
    logic [1:0][TIMER_W-1:0] limit;
    logic [1:0]         cond, fire;
    event_s             ev_ff, nxt_ev;
    logic [2:0][15:0]   axes;
    logic [2:0]         tap_hit, act_hit, still_ok, fall_ok;
    logic               above, active, quiet, falling;

    assign axes = {sample_in.x, sample_in.y, sample_in.z};

    // Per-axis magnitude compares
    for (genvar g = 0; g < 3; g++) begin : g_axis
        logic [15:0] mag_full;
        logic [11:0] mag;
        assign mag_full    = axes[g][15] ? 16'(~axes[g] + 16'h1) : axes[g];
        assign mag         = mag_full[15:THRESH_SHIFT];
        assign tap_hit[g]  = mag > {4'h0, cfg_in.tap_thr};
        assign act_hit[g]  = mag > {4'h0, cfg_in.act_thr};
        assign still_ok[g] = mag < {4'h0, cfg_in.still_thr};
        assign fall_ok[g]  = mag < {4'h0, cfg_in.fall_thr};
    end

    assign above   = |tap_hit;
    assign active  = |(act_hit & cfg_in.axis_ctl[ACT_AXIS_LSB +: 3]);
    assign quiet   = &(still_ok | ~cfg_in.axis_ctl[STILL_AXIS_LSB +: 3])
                   & |cfg_in.axis_ctl[STILL_AXIS_LSB +: 3];
    assign falling = &fall_ok;
    assign cond    = {falling, quiet};
    assign limit[0] = TIMER_W'(cfg_in.still_time * STILL_TICKS);
    assign limit[1] = TIMER_W'(cfg_in.fall_time * FALL_TICKS);

    // Base tick divider
    always_comb begin
        nxt_tick = 1'b0;
        nxt_div  = div_ff + DW'(1);
        if (div_ff == DW'(TICK_CYCLES - 1)) begin
            nxt_div  = '0;
            nxt_tick = 1'b1;
        end
    end

    // Tap sequencer
    always_comb begin
        nxt_tap = tap_ff;
        nxt_cnt = (tick_ff && cnt_ff != 10'h3ff) ? cnt_ff + 10'h1 : cnt_ff;
        nxt_ev.single_tap = 1'b0;
        nxt_ev.double_tap = 1'b0;
        case (tap_ff)
            TAP_IDLE: begin
                nxt_cnt = '0;
                if (above) begin
                    nxt_tap = TAP_FIRST;
                end
            end
            TAP_FIRST, TAP_SECOND: begin
                if (!above) begin
                    nxt_tap = TAP_IDLE;
                    nxt_cnt = '0;
                    if (cnt_ff < {2'h0, cfg_in.tap_dur}) begin
                        if (tap_ff == TAP_FIRST) begin
                            nxt_ev.single_tap = 1'b1;
                            if (cfg_in.tap_win != 8'h00) begin
                                nxt_tap = TAP_LATENT;
                            end
                        end else begin
                            nxt_ev.double_tap = 1'b1;
                        end
                    end
                end else if (cnt_ff >= {2'h0, cfg_in.tap_dur}) begin
                    nxt_tap = TAP_HOLD;
                end
            end
            TAP_HOLD: begin
                if (!above) begin
                    nxt_tap = TAP_IDLE;
                end
            end
            TAP_LATENT: begin
                if (cnt_ff >= 10'(cfg_in.tap_lat * LAT_TICKS)) begin
                    nxt_tap = TAP_WINDOW;
                    nxt_cnt = '0;
                end
            end
            TAP_WINDOW: begin
                if (above) begin
                    nxt_tap = TAP_SECOND;
                    nxt_cnt = '0;
                end else if (cnt_ff >= 10'(cfg_in.tap_win * LAT_TICKS)) begin
                    nxt_tap = TAP_IDLE;
                end
            end
            default: begin
                nxt_tap = TAP_IDLE;
            end
        endcase
        nxt_ev.activity  = sample_new_in & active;
        nxt_ev.stillness = fire[0];
        nxt_ev.free_fall = fire[1];
    end

    // Duration timers: 0 stillness, 1 free fall
    for (genvar t = 0; t < 2; t++) begin : g_timer
        always_comb begin
            nxt_tmr[t] = tmr_ff[t];
            fire[t]    = 1'b0;
            if (!cond[t]) begin
                nxt_tmr[t] = '0;
            end else if (tick_ff && tmr_ff[t] <= limit[t]) begin
                nxt_tmr[t] = tmr_ff[t] + TIMER_W'(1);
                fire[t]    = tmr_ff[t] == limit[t];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
            tap_ff  <= TAP_IDLE;
            cnt_ff  <= '0;
            tmr_ff  <= '0;
            ev_ff   <= '0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
            tap_ff  <= nxt_tap;
            cnt_ff  <= nxt_cnt;
            tmr_ff  <= nxt_tmr;
            ev_ff   <= nxt_ev;
        end
    end

    assign events_out = ev_ff;

endmodule
`default_nettype wire

// >>> test/host_model.sv
// Host model driving the register port of the motion interrupt logic
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk_in,
    output logic            wr_out,
    output logic            rd_out,
    output logic [5:0]      addr_out,
    output logic [7:0]      wdata_out
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 8'h00;
    end
    // One register access, held across one taking edge
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_out = w;
        rd_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule
`default_nettype wire

// >>> test/motion_event_interrupts_bench.sv
// Self-checking bench for the motion interrupt logic
`timescale 1ns/1ps
`default_nettype none
module motion_event_interrupts_bench;
    import motion_irq_pkg::*;
    logic        clk_in, rstn_in, wr, rd, sv, pa, pb, rd_taken;
    logic [5:0]  addr;
    logic [7:0]  wd, rdata, v;
    logic [15:0] w;
    sample_s     smp, s;
    buf_status_s bs;
    logic [7:0]  expq[$];
    int          fails, checked;
    host_model u_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd));
    motion_event_interrupts #(.TICK_CYCLES(4)) u_motion_event_interrupts (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .sample_valid_in(sv), .sample_in(smp),
        .buf_status_in(bs), .irq_pin_a_out(pa), .irq_pin_b_out(pb));
    task automatic bad(input string m);
        fails++;
        $display("Error %0t %s", $time, m);
    endtask
    task automatic give_verdict;
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.acc(1'b0, a, 8'h00);
    endtask
    task automatic pins(input logic a, input logic b);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        checked++;
        if (pa !== a || pb !== b) bad("pin level");
    endtask
    task automatic sample(input sample_s x);
        @(posedge clk_in);
        #1;
        smp = x;
        sv = 1'b1;
        @(posedge clk_in);
        #1;
        sv = 1'b0;
        smp = ~x;
        repeat (6) @(posedge clk_in);
    endtask
    // Read results land on the taking edge and are checked at the next falling edge
    always @(posedge clk_in) rd_taken <= rd;
    always @(negedge clk_in) begin
        if (rd_taken) begin
            checked++;
            if (expq.size() == 0) bad("unexpected read");
            else if (rdata !== expq.pop_front()) bad("read data");
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        #2000000;
        bad("timeout");
        give_verdict();
    end
    initial begin
        rstn_in = 1'b0;
        sv = 1'b0;
        smp = '0;
        bs = {6'd0, 5'd4, 1'b0};
        v = 8'($urandom(32'h09787e87));
        repeat (8) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        pins(1'b0, 1'b0);
        for (int i = 0; i < NUM_RW; i++) begin
            rd_chk(RW_ADDR[i], REG_RESET);
            v = 8'($urandom);
            u_host.acc(1'b1, RW_ADDR[i], v);
            rd_chk(RW_ADDR[i], v);
            u_host.acc(1'b1, RW_ADDR[i], 8'h00);
        end
        rd_chk(6'h3f, 8'h00);
        @(posedge clk_in);
        #1;
        rstn_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        pins(1'b0, 1'b0);
        u_host.acc(1'b1, ADDR_IRQ_CAUSE, 8'hff);
        rd_chk(ADDR_IRQ_CAUSE, 8'h00);
        s = {16'($urandom), 32'($urandom)};
        sample(s);
        pins(1'b0, 1'b0);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h80);
        pins(1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            w = 16'(s >> (32 - 16 * (i / 2)));
            rd_chk(ADDR_SAMPLE_FIRST + 6'(i), (i % 2) ? w[15:8] : w[7:0]);
        end
        pins(1'b0, 1'b0);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h00);
        u_host.acc(1'b1, ADDR_MOTION_THRESHOLD, 8'h10);
        u_host.acc(1'b1, ADDR_MOTION_AXIS_CTL, 8'h40);
        u_host.acc(1'b1, ADDR_IRQ_PIN_SELECT, 8'h10);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h10);
        sample({16'h0000, 16'h7fff, 16'h0000});
        pins(1'b0, 1'b0);
        sample({16'hfe00, 32'h0});
        sample('0);
        pins(1'b0, 1'b1);
        rd_chk(ADDR_IRQ_CAUSE, 8'h90);
        rd_chk(ADDR_IRQ_CAUSE, 8'h80);
        pins(1'b0, 1'b0);
        u_host.acc(1'b1, ADDR_OUTPUT_FORMAT, 8'h20);
        pins(1'b1, 1'b1);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h03);
        @(posedge clk_in);
        #1;
        bs = {6'd4, 5'd4, 1'b1};
        @(posedge clk_in);
        #1;
        bs = {6'd3, 5'd4, 1'b0};
        pins(1'b0, 1'b1);
        rd_chk(ADDR_SAMPLE_FIRST, 8'h00);
        pins(1'b1, 1'b1);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h00);
        u_host.acc(1'b1, ADDR_OUTPUT_FORMAT, 8'h00);
        u_host.acc(1'b1, ADDR_TAP_THRESHOLD, 8'h10);
        u_host.acc(1'b1, ADDR_TAP_MAX_DURATION, 8'h04);
        u_host.acc(1'b1, ADDR_TAP_LATENCY, 8'h01);
        u_host.acc(1'b1, ADDR_SECOND_TAP_WIN, 8'h08);
        u_host.acc(1'b1, ADDR_IRQ_PIN_SELECT, 8'h40);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h60);
        sample({16'hfe00, 32'h0});
        sample('0);
        sample('0);
        sample({16'hfe00, 32'h0});
        sample('0);
        pins(1'b1, 1'b1);
        rd_chk(ADDR_IRQ_CAUSE, 8'hf0);
        pins(1'b0, 1'b0);
        u_host.acc(1'b1, ADDR_FALL_TIME, 8'h01);
        u_host.acc(1'b1, ADDR_FALL_THRESHOLD, 8'h02);
        u_host.acc(1'b1, ADDR_IRQ_ENABLE_MASK, 8'h04);
        repeat (48) @(posedge clk_in);
        pins(1'b1, 1'b0);
        rd_chk(ADDR_IRQ_CAUSE, 8'h84);
        give_verdict();
    end
endmodule
`default_nettype wire
